// File: hdl/cad_pkg.sv
// Shared constants, operation codes and carrier types of the arithmetic datapath
package cad_pkg;

  // ---------------------------------------------------------------
  // Widths and constants
  // ---------------------------------------------------------------
  localparam int              WORD_W      = 16;
  localparam int              PAIR_W      = 32;
  localparam int              ACC_W       = 40;
  localparam logic [5:0]      QUO_STEPS   = 6'h20;
  localparam logic [15:0]     STEP_ONE    = 16'h0001;
  localparam logic [15:0]     STEP_TWO    = 16'h0002;
  localparam logic [15:0]     QUO_ZERO_Q  = 16'hFFFF;
  localparam logic [ACC_W-1:0] ROUND_ADD  = 40'h00_0000_8000;
  localparam logic [ACC_W-1:0] ROUND_MASK = 40'hFF_FFFF_0000;

  // ---------------------------------------------------------------
  // Operations
  // ---------------------------------------------------------------
  typedef enum logic [5:0] {
    OP_SUM, OP_SUM_WITH_CARRY, OP_DIFF, OP_DIFFERENCE_WITH_BORROW,
    OP_PRODUCT, OP_QUOTIENT_SHORT, OP_QUOTIENT_LONG,
    OP_ONES_COMPLEMENT, OP_NEGATE, OP_AND, OP_OR, OP_XOR,
    OP_SINGLE_BIT_CLEAR_SET, OP_BIT_COPY, OP_BIT_LOGIC, OP_BIT_COMPARE,
    OP_MASKED_BYTE_MODIFY, OP_COMPARE, OP_COMPARE_THEN_DECREMENT,
    OP_COMPARE_THEN_INCREMENT, OP_NORMALIZE_COUNT, OP_LOGICAL_SHIFT,
    OP_BIT_ROTATE, OP_SIGN_SHIFT_RIGHT, OP_BYTE_WIDEN_MOVE,
    OP_ACC_LOAD, OP_ACC_STORE, OP_COPROC_MULTIPLY, OP_MAC_ADD, OP_MAC_SUB,
    OP_MAC_SHIFT, OP_MAC_COMPARE, OP_MAC_MINMAX, OP_MAC_ABS, OP_MAC_ROUND,
    OP_MAC_NEGATE, OP_MAC_MOVE
  } cad_op_type;

  typedef enum logic [1:0] {BITFN_AND, BITFN_OR, BITFN_XOR} cad_bitfn_type;

  typedef enum logic {ST_IDLE, ST_QUOTIENT} cad_st_type;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    cad_op_type    op;
    logic          byte_mode;
    logic          is_signed;
    logic          variant;
    cad_bitfn_type bit_fn;
    logic [15:0]   a;
    logic [15:0]   b;
    logic [3:0]    pos_a;
    logic [3:0]    pos_b;
    logic [7:0]    mask;
    logic [7:0]    imm;
  } cad_req_type;

  typedef struct packed {
    logic z;
    logic n;
    logic c;
    logic v;
  } cad_flags_type;

  typedef struct packed {
    logic [15:0]   data;
    cad_flags_type f;
  } cad_alu_type;

  typedef struct packed {
    cad_st_type    st;
    logic          done;
    logic          wr;
    logic [15:0]   res;
    cad_flags_type fl;
    logic [31:0]   muldiv_pair;
    logic [39:0]   acc;
    logic          neg_q;
    logic          neg_r;
    logic          sgn;
  } cad_state_type;

  typedef struct packed {
    logic        busy;
    logic        done;
    logic        dz;
    logic [5:0]  cnt;
    logic [15:0] dvs;
    logic [31:0] quo;
    logic [15:0] rem;
  } cad_quo_state_type;

  localparam cad_state_type     STATE_RESET = '0;
  localparam cad_quo_state_type QUO_RESET   = '0;

endpackage : cad_pkg

// File: hdl/cad_divider.sv
// Iterative unsigned 32 by 16 restoring divider
`timescale 1ns/100ps
module cad_divider (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // Request
  input  wire logic        start,
  input  wire logic [31:0] dividend,
  input  wire logic [15:0] divisor,
  // Answer
  output logic             done,
  output logic             div_zero,
  output logic [31:0]      quotient,
  output logic [15:0]      remainder
);

  cad_pkg::cad_quo_state_type q;
  cad_pkg::cad_quo_state_type d;

  always_comb begin
    logic [16:0] trial;
    logic [16:0] diff;
    trial  = {q.rem, q.quo[31]};
    diff   = trial - {1'b0, q.dvs};
    d      = q;
    d.done = 1'b0;
    if (!q.busy) begin
      if (start) begin
        if (divisor == 16'h0000) begin
          d.done = 1'b1;
          d.dz   = 1'b1;
          d.quo  = {16'h0000, cad_pkg::QUO_ZERO_Q};
          d.rem  = dividend[15:0];
        end else begin
          d.busy = 1'b1;
          d.dz   = 1'b0;
          d.cnt  = cad_pkg::QUO_STEPS;
          d.dvs  = divisor;
          d.quo  = dividend;
          d.rem  = 16'h0000;
        end
      end
    end else begin
      // One quotient bit per clock keeps the subtractor to 17 bits
      if (!diff[16]) begin
        d.rem = diff[15:0];
        d.quo = {q.quo[30:0], 1'b1};
      end else begin
        d.rem = trial[15:0];
        d.quo = {q.quo[30:0], 1'b0};
      end
      d.cnt = q.cnt - 6'h01;
      if (q.cnt == 6'h01) begin
        d.busy = 1'b0;
        d.done = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= cad_pkg::QUO_RESET;
    end else begin
      q <= d;
    end
  end

  assign done      = q.done;
  assign div_zero  = q.dz;
  assign quotient  = q.quo;
  assign remainder = q.rem;

endmodule : cad_divider

// File: hdl/cad_datapath.sv
// Arithmetic, logic, bit, shift, multiply/divide and accumulate datapath
`timescale 1ns/100ps
// Operation
// - add word or byte, optionally with carry
// - subtract word or byte, optionally with borrow
// - signed or unsigned 16x16 product to pair
// - short divide low pair word by operand
// - long divide full pair by operand
// - ones complement or twos negate register
// - bitwise and, or, xor on words/bytes
// - bit clear/set, copy, logic, compare
// - masked immediate write into one byte
// - compare sets flags, operands unchanged
// - compare then decrement by one or two
// - compare then increment by one or two
// - count shifts needed to normalize word
// - logical shifts and rotations of word
// - arithmetic right shift keeps sign bit
// - byte to word, sign or zero extend
// - accumulator unit load, store, arithmetic ops
module cad_datapath (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 rstn,
  // Request from the decoder
  input  wire logic                 req_valid,
  input  wire cad_pkg::cad_req_type req,
  output logic                      req_ready,
  // Result to the register file
  output logic                      done,
  output logic                      wr_en,
  output logic [15:0]               result,
  output cad_pkg::cad_flags_type    flags,
  // Architectural state
  output logic [31:0]               muldiv_pair,
  output logic [39:0]               accumulator
);

  // ---------------------------------------------------------------
  // Helper functions
  // ---------------------------------------------------------------
  function automatic cad_pkg::cad_alu_type arith(input logic [15:0] a, input logic [15:0] b,
                                                 input logic cin, input logic sub,
                                                 input logic bm);
    cad_pkg::cad_alu_type o;
    logic [16:0]          s;
    logic                 ma;
    logic                 mb;
    logic                 mr;
    if (bm) begin
      s = sub ? ({9'h000, a[7:0]} - {9'h000, b[7:0]} - {16'h0000, cin})
              : ({9'h000, a[7:0]} + {9'h000, b[7:0]} + {16'h0000, cin});
    end else begin
      s = sub ? ({1'b0, a} - {1'b0, b} - {16'h0000, cin})
              : ({1'b0, a} + {1'b0, b} + {16'h0000, cin});
    end
    ma     = bm ? a[7] : a[15];
    mb     = bm ? b[7] : b[15];
    mr     = bm ? s[7] : s[15];
    o.data = bm ? {a[15:8], s[7:0]} : s[15:0];
    o.f.z  = bm ? (s[7:0] == 8'h00) : (s[15:0] == 16'h0000);
    o.f.n  = mr;
    o.f.c  = bm ? s[8] : s[16];
    o.f.v  = sub ? ((ma ^ mb) & (ma ^ mr)) : (~(ma ^ mb) & (ma ^ mr));
    return o;
  endfunction : arith

  // Byte results keep the upper byte of the destination
  function automatic cad_pkg::cad_alu_type logic_res(input logic [15:0] r, input logic [15:0] a,
                                                     input logic bm);
    cad_pkg::cad_alu_type o;
    o.data = bm ? {a[15:8], r[7:0]} : r;
    o.f.z  = bm ? (r[7:0] == 8'h00) : (r == 16'h0000);
    o.f.n  = bm ? r[7] : r[15];
    o.f.c  = 1'b0;
    o.f.v  = 1'b0;
    return o;
  endfunction : logic_res

  function automatic logic [15:0] lead_shifts(input logic [15:0] a);
    logic [15:0] n;
    logic        found;
    n     = 16'h0000;
    found = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      if (!found) begin
        if (a[i]) begin
          found = 1'b1;
        end else begin
          n = n + 16'h0001;
        end
      end
    end
    // A zero word needs no shifts and reports zero
    if (!found) begin
      n = 16'h0000;
    end
    return n;
  endfunction : lead_shifts

  function automatic cad_pkg::cad_flags_type acc_flags(input logic [39:0] v);
    cad_pkg::cad_flags_type f;
    f.z = (v == 40'h00_0000_0000);
    f.n = v[39];
    f.c = 1'b0;
    f.v = 1'b0;
    return f;
  endfunction : acc_flags

  // ---------------------------------------------------------------
  // Divider
  // ---------------------------------------------------------------
  cad_pkg::cad_state_type q;
  cad_pkg::cad_state_type d;
  logic                   quo_start;
  logic [31:0]            quo_dividend;
  logic [15:0]            quo_divisor;
  logic                   quo_done;
  logic                   quo_zero;
  logic [31:0]            quo_q;
  logic [15:0]            quo_r;

  cad_divider u_divider (
    .clk       (clk),
    .rstn      (rstn),
    .start     (quo_start),
    .dividend  (quo_dividend),
    .divisor   (quo_divisor),
    .done      (quo_done),
    .div_zero  (quo_zero),
    .quotient  (quo_q),
    .remainder (quo_r)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    cad_pkg::cad_alu_type  ar;
    logic [15:0]           a;
    logic [15:0]           b;
    logic [3:0]            n;
    logic [16:0]           sl;
    logic [16:0]           sr;
    logic signed [16:0]    sa;
    logic [31:0]           rl;
    logic [31:0]           rr;
    logic [31:0]           pu;
    logic signed [31:0]    ps;
    logic [31:0]           raw;
    logic [39:0]           mop;
    logic [39:0]           mprod;
    logic [40:0]           msum;
    logic [40:0]           mdif;
    logic [39:0]           anew;
    logic [31:0]           qs;
    logic [15:0]           rs;
    logic [15:0]           tmp;
    logic [7:0]            byte_in;
    logic                  sb;
    logic                  da;
    logic                  bitv;
    a       = req.a;
    b       = req.b;
    n       = req.b[3:0];
    sl      = {1'b0, a} << n;
    sr      = {a, 1'b0} >> n;
    sa      = $signed({a, 1'b0}) >>> n;
    rl      = {a, a} << n;
    rr      = {a, a} >> n;
    pu      = 32'(a) * 32'(b);
    ps      = 32'($signed(a)) * 32'($signed(b));
    raw     = (req.op == cad_pkg::OP_QUOTIENT_LONG) ? q.muldiv_pair
            : (req.is_signed ? {{16{q.muldiv_pair[15]}}, q.muldiv_pair[15:0]}
                             : {16'h0000, q.muldiv_pair[15:0]});
    mop     = req.is_signed ? {{8{a[15]}}, a, b} : {8'h00, a, b};
    mprod   = req.is_signed ? {{8{ps[31]}}, ps} : {8'h00, pu};
    msum    = {1'b0, q.acc} + {1'b0, mop};
    mdif    = {1'b0, q.acc} - {1'b0, mop};
    anew    = q.acc;
    sb      = b[req.pos_b];
    da      = a[req.pos_a];
    bitv    = 1'b0;
    tmp     = a;
    byte_in = req.variant ? a[15:8] : a[7:0];
    ar      = logic_res(a, a, 1'b0);
    qs      = quo_q;
    rs      = quo_r;
    d       = q;
    d.done  = 1'b0;
    d.wr    = 1'b0;
    req_ready    = (q.st == cad_pkg::ST_IDLE);
    quo_start    = 1'b0;
    quo_dividend = (req.is_signed && raw[31]) ? (32'h0000_0000 - raw) : raw;
    quo_divisor  = (req.is_signed && b[15]) ? (16'h0000 - b) : b;

    case (q.st)
      cad_pkg::ST_IDLE: begin
        if (req_valid) begin
          d.done = 1'b1;
          d.wr   = 1'b1;
          case (req.op)
            cad_pkg::OP_SUM:            ar = arith(a, b, 1'b0, 1'b0, req.byte_mode);
            cad_pkg::OP_SUM_WITH_CARRY: ar = arith(a, b, q.fl.c, 1'b0, req.byte_mode);
            cad_pkg::OP_DIFF:           ar = arith(a, b, 1'b0, 1'b1, req.byte_mode);
            cad_pkg::OP_DIFFERENCE_WITH_BORROW: begin
              ar = arith(a, b, q.fl.c, 1'b1, req.byte_mode);
            end
            cad_pkg::OP_PRODUCT: begin
              d.wr          = 1'b0;
              d.muldiv_pair = req.is_signed ? ps : pu;
              ar.f.z        = req.is_signed ? (ps == 32'sh0) : (pu == 32'h0);
              ar.f.n        = req.is_signed ? ps[31] : 1'b0;
              ar.f.c        = 1'b0;
              ar.f.v        = req.is_signed ? (ps[31:16] != {16{ps[15]}}) : (pu[31:16] != 16'h0);
            end
            cad_pkg::OP_QUOTIENT_SHORT, cad_pkg::OP_QUOTIENT_LONG: begin
              d.done    = 1'b0;
              d.wr      = 1'b0;
              quo_start = 1'b1;
              d.st      = cad_pkg::ST_QUOTIENT;
              d.sgn     = req.is_signed;
              d.neg_r   = req.is_signed & raw[31];
              d.neg_q   = req.is_signed & (raw[31] ^ b[15]);
            end
            cad_pkg::OP_ONES_COMPLEMENT: ar = logic_res(~a, a, req.byte_mode);
            cad_pkg::OP_NEGATE:          ar = arith(16'h0000, a, 1'b0, 1'b1, req.byte_mode);
            cad_pkg::OP_AND:             ar = logic_res(a & b, a, req.byte_mode);
            cad_pkg::OP_OR:              ar = logic_res(a | b, a, req.byte_mode);
            cad_pkg::OP_XOR:             ar = logic_res(a ^ b, a, req.byte_mode);
            cad_pkg::OP_SINGLE_BIT_CLEAR_SET, cad_pkg::OP_BIT_COPY, cad_pkg::OP_BIT_LOGIC,
            cad_pkg::OP_BIT_COMPARE: begin
              case (req.op)
                cad_pkg::OP_SINGLE_BIT_CLEAR_SET: bitv = req.variant;
                cad_pkg::OP_BIT_COPY:             bitv = sb ^ req.variant;
                cad_pkg::OP_BIT_LOGIC: begin
                  case (req.bit_fn)
                    cad_pkg::BITFN_AND: bitv = da & sb;
                    cad_pkg::BITFN_OR:  bitv = da | sb;
                    default:            bitv = da ^ sb;
                  endcase
                end
                default: bitv = da;
              endcase
              tmp[req.pos_a] = bitv;
              d.wr   = (req.op != cad_pkg::OP_BIT_COMPARE);
              ar.data = tmp;
              ar.f.z = ~(da | sb);
              ar.f.n = da ^ sb;
              ar.f.c = da & sb;
              ar.f.v = da | sb;
            end
            cad_pkg::OP_MASKED_BYTE_MODIFY: begin
              byte_in = (byte_in & ~req.mask) | (req.imm & req.mask);
              tmp     = req.variant ? {byte_in, a[7:0]} : {a[15:8], byte_in};
              ar      = logic_res(tmp, tmp, 1'b0);
            end
            cad_pkg::OP_COMPARE: begin
              ar   = arith(a, b, 1'b0, 1'b1, req.byte_mode);
              d.wr = 1'b0;
            end
            cad_pkg::OP_COMPARE_THEN_DECREMENT: begin
              ar      = arith(a, b, 1'b0, 1'b1, 1'b0);
              ar.data = a - (req.variant ? cad_pkg::STEP_TWO : cad_pkg::STEP_ONE);
            end
            cad_pkg::OP_COMPARE_THEN_INCREMENT: begin
              ar      = arith(a, b, 1'b0, 1'b1, 1'b0);
              ar.data = a + (req.variant ? cad_pkg::STEP_TWO : cad_pkg::STEP_ONE);
            end
            cad_pkg::OP_NORMALIZE_COUNT: ar = logic_res(lead_shifts(a), a, 1'b0);
            // shifts and rotations, carry is last bit out
            cad_pkg::OP_LOGICAL_SHIFT: begin
              ar     = logic_res(req.variant ? sr[16:1] : sl[15:0], a, 1'b0);
              ar.f.c = (n != 4'h0) & (req.variant ? sr[0] : sl[16]);
            end
            cad_pkg::OP_BIT_ROTATE: begin
              ar     = logic_res(req.variant ? rr[15:0] : rl[31:16], a, 1'b0);
              ar.f.c = (n != 4'h0) & (req.variant ? rr[15] : rl[16]);
            end
            cad_pkg::OP_SIGN_SHIFT_RIGHT: begin
              ar     = logic_res(sa[16:1], a, 1'b0);
              ar.f.c = (n != 4'h0) & sa[0];
            end
            cad_pkg::OP_BYTE_WIDEN_MOVE: begin
              ar = logic_res({req.variant ? {8{b[7]}} : 8'h00, b[7:0]}, a, 1'b0);
            end
            cad_pkg::OP_ACC_STORE: begin
              ar = logic_res(req.variant ? q.acc[31:16] : q.acc[15:0], a, 1'b0);
            end
            cad_pkg::OP_MAC_MOVE: ar = logic_res(a, a, 1'b0);
            default: begin
              d.wr = 1'b0;
              case (req.op)
                cad_pkg::OP_ACC_LOAD:        anew = mop;
                cad_pkg::OP_COPROC_MULTIPLY: anew = req.variant ? (q.acc + mprod) : mprod;
                cad_pkg::OP_MAC_ADD:         anew = msum[39:0];
                cad_pkg::OP_MAC_SUB:         anew = mdif[39:0];
                cad_pkg::OP_MAC_SHIFT: begin
                  anew = req.variant ? 40'($signed(q.acc) >>> n) : (q.acc << n);
                end
                cad_pkg::OP_MAC_MINMAX: begin
                  anew = (($signed(q.acc) > $signed(mop)) == req.variant) ? q.acc : mop;
                end
                cad_pkg::OP_MAC_ABS:    anew = q.acc[39] ? (40'h00_0000_0000 - q.acc) : q.acc;
                cad_pkg::OP_MAC_ROUND:  anew = (q.acc + cad_pkg::ROUND_ADD) & cad_pkg::ROUND_MASK;
                cad_pkg::OP_MAC_NEGATE: anew = 40'h00_0000_0000 - q.acc;
                default:                anew = q.acc;
              endcase
              if (req.op == cad_pkg::OP_MAC_COMPARE) begin
                ar.f   = acc_flags(mdif[39:0]);
                ar.f.c = mdif[40];
              end else begin
                d.acc  = anew;
                ar.f   = acc_flags(anew);
                ar.f.c = (req.op == cad_pkg::OP_MAC_ADD) ? msum[40]
                       : ((req.op == cad_pkg::OP_MAC_SUB) ? mdif[40] : 1'b0);
              end
            end
          endcase
          if (d.done) begin
            d.res = ar.data;
            d.fl  = ar.f;
          end
        end
      end
      cad_pkg::ST_QUOTIENT: begin
        // Decoder waits on req_ready while the divider iterates
        if (quo_done) begin
          qs     = q.neg_q ? (32'h0000_0000 - quo_q) : quo_q;
          rs     = q.neg_r ? (16'h0000 - quo_r) : quo_r;
          d.st   = cad_pkg::ST_IDLE;
          d.done = 1'b1;
          if (quo_zero) begin
            d.muldiv_pair = {quo_r, cad_pkg::QUO_ZERO_Q};
            d.fl          = '{z: 1'b0, n: 1'b1, c: 1'b0, v: 1'b1};
          end else begin
            d.muldiv_pair = {rs, qs[15:0]};
            d.fl.z        = (qs[15:0] == 16'h0000);
            d.fl.n        = qs[15];
            d.fl.c        = 1'b0;
            d.fl.v        = q.sgn ? (qs[31:16] != {16{qs[15]}}) : (qs[31:16] != 16'h0000);
          end
          d.res = d.muldiv_pair[15:0];
        end
      end
      default: d.st = cad_pkg::ST_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= cad_pkg::STATE_RESET;
    end else begin
      q <= d;
    end
  end

  assign done        = q.done;
  assign wr_en       = q.wr;
  assign result      = q.res;
  assign flags       = q.fl;
  assign muldiv_pair = q.muldiv_pair;
  assign accumulator = q.acc;

endmodule : cad_datapath

// File: sim/cad_datapath_chk.sv
// Port-level assertions of the arithmetic datapath
`timescale 1ns/100ps
module cad_datapath_chk (
  // Clock and reset
  input wire logic                   clk,
  input wire logic                   rstn,
  // Request
  input wire logic                   req_valid,
  input wire cad_pkg::cad_req_type   req,
  input wire logic                   req_ready,
  // Answer
  input wire logic                   done,
  input wire logic                   wr_en,
  input wire logic [15:0]            result,
  input wire cad_pkg::cad_flags_type flags,
  input wire logic [31:0]            muldiv_pair,
  input wire logic [39:0]            accumulator
);
  cad_pkg::cad_req_type p_q;
  logic                 tk;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  assign tk = req_valid && req_ready;
  // Request seen at the taking edge, judged one cycle later
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      p_q <= '0;
    end else begin
      p_q <= req;
    end
  end
  sum_word_a: assert property (tk && req.op == cad_pkg::OP_SUM && !req.byte_mode
    |=> done && wr_en && result == 16'(p_q.a + p_q.b) && flags.z == (result == 16'h0))
    else $error("word sum wrong");
  diff_word_a: assert property (tk && req.op == cad_pkg::OP_DIFF && !req.byte_mode
    |=> result == 16'(p_q.a - p_q.b) && flags.c == (p_q.a < p_q.b))
    else $error("word difference wrong");
  product_pair_a: assert property (tk && req.op == cad_pkg::OP_PRODUCT && !req.is_signed
    |=> done && !wr_en && muldiv_pair == 32'(p_q.a) * 32'(p_q.b))
    else $error("unsigned product wrong");
  and_word_a: assert property (tk && req.op == cad_pkg::OP_AND && !req.byte_mode
    |=> result == (p_q.a & p_q.b))
    else $error("word and wrong");
  cmp_nowrite_a: assert property (tk && req.op == cad_pkg::OP_COMPARE
    |=> done && !wr_en)
    else $error("compare wrote a result");
  cmp_dec_a: assert property (tk && req.op == cad_pkg::OP_COMPARE_THEN_DECREMENT
    |=> wr_en && result == 16'(p_q.a - (p_q.variant ? 16'h0002 : 16'h0001)))
    else $error("decrement step wrong");
  sign_shift_a: assert property (tk && req.op == cad_pkg::OP_SIGN_SHIFT_RIGHT
    |=> result == 16'($signed(p_q.a) >>> p_q.b[3:0]))
    else $error("arithmetic shift wrong");
  widen_move_a: assert property (tk && req.op == cad_pkg::OP_BYTE_WIDEN_MOVE
    |=> result == (p_q.variant ? {{8{p_q.b[7]}}, p_q.b[7:0]} : {8'h00, p_q.b[7:0]}))
    else $error("byte widening wrong");
  div_zero_a: assert property (tk && req.b == 16'h0000
    && req.op inside {cad_pkg::OP_QUOTIENT_SHORT, cad_pkg::OP_QUOTIENT_LONG}
    |=> !req_ready ##1 done && flags.v && req_ready)
    else $error("zero divisor not flagged in time");
  div_time_a: assert property (tk && req.b != 16'h0000
    && req.op inside {cad_pkg::OP_QUOTIENT_SHORT, cad_pkg::OP_QUOTIENT_LONG}
    |=> !done [*8] ##26 done && !wr_en)
    else $error("division latency wrong");
endmodule : cad_datapath_chk

bind cad_datapath cad_datapath_chk i_chk (.clk(clk), .rstn(rstn), .req_valid(req_valid),
  .req(req), .req_ready(req_ready), .done(done), .wr_en(wr_en), .result(result),
  .flags(flags), .muldiv_pair(muldiv_pair), .accumulator(accumulator));

// File: sim/cad_decoder_model.sv
// Decoder stand-in: issues one request, then waits for its answer
`timescale 1ns/100ps
module cad_decoder_model (
  // Clock
  input wire logic             clk,
  // Request
  output cad_pkg::cad_req_type req,
  output logic                 req_valid,
  input wire logic             req_ready,
  // Answer
  input wire logic             done,
  input wire logic             wr_en,
  output logic                 wr_q
);
  int gap = 0;
  initial begin
    req_valid = 1'b0;
    req       = '0;
    wr_q      = 1'b0;
  end
  task issue(input cad_pkg::cad_req_type r);
    repeat (gap) @(posedge clk);
    @(posedge clk);
    req_valid <= 1'b1;
    req       <= r;
    do @(posedge clk); while (req_ready !== 1'b1);
    req_valid <= 1'b0;
    // Released fields must not keep showing the last value
    req       <= cad_pkg::cad_req_type'(~r);
    #1;
    // Bench watchdog ends a hang
    while (done !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    wr_q = wr_en;
  endtask : issue
endmodule : cad_decoder_model

// File: sim/cad_datapath_tb.sv
// Self-checking bench of the arithmetic datapath
`timescale 1ns/100ps
module cad_datapath_tb;
  logic clk, rstn, req_valid, req_ready, done, wr_en, wr_q;
  logic [15:0] result;
  logic [31:0] muldiv_pair;
  logic [39:0] accumulator;
  cad_pkg::cad_req_type req, x;
  cad_pkg::cad_flags_type flags;
  int err_total = 0;
  int n_checks = 0;
  always #50 clk = ~clk;
  cad_datapath i_dut (.clk(clk), .rstn(rstn), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .done(done), .wr_en(wr_en), .result(result), .flags(flags),
    .muldiv_pair(muldiv_pair), .accumulator(accumulator));
  cad_decoder_model i_dec (.clk(clk), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .done(done), .wr_en(wr_en), .wr_q(wr_q));
  task chk(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task go(input cad_pkg::cad_op_type o, input logic [15:0] a, b, input logic v);
    x.op = o;
    x.a = a;
    x.b = b;
    x.variant = v;
    i_dec.issue(x);
    x = '0;
  endtask : go
  task gc(input cad_pkg::cad_op_type o, input logic [15:0] a, b, input logic v, logic [15:0] e);
    go(o, a, b, v);
    chk(result, e);
  endtask : gc
  task t_arith;
    gc(cad_pkg::OP_SUM, 16'hFFFF, 16'h0001, 1'b0, 16'h0000);
    chk(flags, 4'hA);
    gc(cad_pkg::OP_SUM_WITH_CARRY, 16'h0001, 16'h0001, 1'b0, 16'h0003);
    gc(cad_pkg::OP_DIFF, 16'h0000, 16'h0001, 1'b0, 16'hFFFF);
    chk(flags, 4'h6);
    gc(cad_pkg::OP_DIFFERENCE_WITH_BORROW, 16'h0005, 16'h0001, 1'b0, 16'h0003);
    x.byte_mode = 1'b1;
    gc(cad_pkg::OP_SUM, 16'h12FF, 16'h0001, 1'b0, 16'h1200);
  endtask : t_arith
  task t_logic;
    gc(cad_pkg::OP_ONES_COMPLEMENT, 16'h00F0, 16'h0, 1'b0, 16'hFF0F);
    gc(cad_pkg::OP_NEGATE, 16'h0001, 16'h0, 1'b0, 16'hFFFF);
    gc(cad_pkg::OP_AND, 16'hF0F0, 16'hFF00, 1'b0, 16'hF000);
    gc(cad_pkg::OP_OR, 16'hF0F0, 16'hFF00, 1'b0, 16'hFFF0);
    gc(cad_pkg::OP_XOR, 16'hF0F0, 16'hFF00, 1'b0, 16'h0FF0);
    x.byte_mode = 1'b1;
    gc(cad_pkg::OP_AND, 16'hABCD, 16'h0F0F, 1'b0, 16'hAB0D);
  endtask : t_logic
  task t_bits;
    x.pos_a = 4'h5;
    gc(cad_pkg::OP_SINGLE_BIT_CLEAR_SET, 16'h0, 16'h0, 1'b1, 16'h0020);
    x.pos_a = 4'h3;
    gc(cad_pkg::OP_BIT_COPY, 16'h0, 16'h0, 1'b1, 16'h0008);
    x.pos_b = 4'hF;
    x.bit_fn = cad_pkg::BITFN_XOR;
    gc(cad_pkg::OP_BIT_LOGIC, 16'h0001, 16'h8000, 1'b0, 16'h0000);
    go(cad_pkg::OP_BIT_COMPARE, 16'h0001, 16'h0, 1'b0);
    chk({wr_q, flags}, 5'h05);
    x.mask = 8'hF0;
    x.imm = 8'hAB;
    gc(cad_pkg::OP_MASKED_BYTE_MODIFY, 16'h1234, 16'h0, 1'b1, 16'hA234);
  endtask : t_bits
  task t_cmp_shift;
    go(cad_pkg::OP_COMPARE, 16'h0005, 16'h0005, 1'b0);
    chk({wr_q, flags}, 5'h08);
    gc(cad_pkg::OP_COMPARE_THEN_DECREMENT, 16'h0010, 16'h0010, 1'b1, 16'h000E);
    gc(cad_pkg::OP_COMPARE_THEN_INCREMENT, 16'h0010, 16'h1, 1'b1, 16'h0012);
    gc(cad_pkg::OP_NORMALIZE_COUNT, 16'h0001, 16'h0, 1'b0, 16'h000F);
    gc(cad_pkg::OP_LOGICAL_SHIFT, 16'h8001, 16'h1, 1'b0, 16'h0002);
    chk(flags.c, 1'b1);
    gc(cad_pkg::OP_BIT_ROTATE, 16'h8001, 16'h1, 1'b1, 16'hC000);
    gc(cad_pkg::OP_SIGN_SHIFT_RIGHT, 16'h8000, 16'h4, 1'b0, 16'hF800);
    gc(cad_pkg::OP_BYTE_WIDEN_MOVE, 16'h1234, 16'h0080, 1'b1, 16'hFF80);
    gc(cad_pkg::OP_BYTE_WIDEN_MOVE, 16'h1234, 16'h0080, 1'b0, 16'h0080);
  endtask : t_cmp_shift
  task t_muldiv;
    i_dec.gap = 3;
    x.is_signed = 1'b1;
    go(cad_pkg::OP_PRODUCT, 16'hFFFF, 16'h0002, 1'b0);
    chk({wr_q, muldiv_pair}, 33'h0FFFFFFFE);
    go(cad_pkg::OP_PRODUCT, 16'h0100, 16'h0100, 1'b0);
    gc(cad_pkg::OP_QUOTIENT_LONG, 16'h0, 16'h0002, 1'b0, 16'h8000);
    chk(muldiv_pair, 32'h00008000);
    go(cad_pkg::OP_QUOTIENT_SHORT, 16'h0, 16'h0010, 1'b0);
    chk(muldiv_pair, 32'h00000800);
    x.is_signed = 1'b1;
    go(cad_pkg::OP_QUOTIENT_SHORT, 16'h0, 16'hFFFF, 1'b0);
    chk(muldiv_pair, 32'h0000F800);
    go(cad_pkg::OP_QUOTIENT_SHORT, 16'h0, 16'h0, 1'b0);
    chk({muldiv_pair, flags}, 36'hF800FFFF5);
    i_dec.gap = 0;
  endtask : t_muldiv
  task t_mac;
    go(cad_pkg::OP_ACC_LOAD, 16'h0001, 16'h0002, 1'b0);
    go(cad_pkg::OP_MAC_ADD, 16'h0, 16'h0001, 1'b0);
    chk(accumulator, 40'h0000010003);
    go(cad_pkg::OP_MAC_ROUND, 16'h0, 16'h0, 1'b0);
    chk(accumulator, 40'h0000010000);
    go(cad_pkg::OP_MAC_NEGATE, 16'h0, 16'h0, 1'b0);
    chk(accumulator, 40'hFFFFFF0000);
    gc(cad_pkg::OP_MAC_MOVE, 16'h1234, 16'h0, 1'b0, 16'h1234);
  endtask : t_mac
  task wrap_up;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : wrap_up
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    x = '0;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_arith();
    t_logic();
    t_bits();
    t_cmp_shift();
    t_muldiv();
    t_mac();
    wrap_up();
  end
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    wrap_up();
  end
endmodule : cad_datapath_tb
